// *** core/inc_dec_skip_jump_or_exec.sv ***
// execute stage for skip-on-zero inc/dec, increment, or-literal and jump
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - decrement-and-skip subtracts one from the file register and touches no status flag.
// - a zero decrement result flushes the next fetched instruction as a no-op, taking two cycles.
// - increment-and-skip adds one without flag change and flushes the next instruction on zero.
// - destination bit 0 sends the result to the accumulator, 1 back to the file register.
// - the jump loads its 11-bit operand into program counter bits 10:0.
// - the jump takes program counter bits 12:11 from bits 4:3 of the upper pc latch.
// - the jump always takes two cycles and alters no status flag.
// - or-literal ors the accumulator with the 8-bit literal, writes the accumulator and updates zero.
// - plain increment adds one, routes by destination bit and updates zero.
module inc_dec_skip_jump_or_exec
  import exec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction from decode
  input wire logic instr_valid,
  input wire logic [op_w-1:0] instr,
  // operands from the core
  input wire logic [data_w-1:0] file_rdata,
  input wire logic [data_w-1:0] acc_in,
  input wire logic [data_w-1:0] upper_pc_latch,
  // results
  output logic acc_we_r,
  output logic [data_w-1:0] acc_wdata_r,
  output logic file_we_r,
  output logic [addr_w-1:0] file_waddr_r,
  output logic [data_w-1:0] file_wdata_r,
  output logic zero_we_r,
  output logic zero_val_r,
  output logic pc_load_r,
  output logic [pc_w-1:0] pc_target_r,
  output logic flush_r,
  output logic busy_r
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [5:0] op6;
  logic [2:0] op3;
  logic hit_dsz, hit_isz, hit_inc, hit_ior, hit_jmp;
  logic is_dsz, is_isz, is_inc, is_ior, is_jmp, go, dest_file;
  logic skip_kind, rmw_kind, two_cycle;
  logic acc_write, file_write, zero_write;
  logic [data_w-1:0] inc_res, dec_res, ior_res, res;
  logic inc_zero, dec_zero, ior_zero, res_zero;
  logic [pc_w-1:0] jump_target;
  exec_state_type state_r, state_nxt;
  assign op6 = instr[op6_lo +: 6];
  assign op3 = instr[op3_lo +: 3];
  // opcode match, independent of whether the slot is live
  always_comb begin
    hit_dsz = 1'b0;
    hit_isz = 1'b0;
    hit_inc = 1'b0;
    hit_ior = 1'b0;
    case (op6)
      op_decrement_skip_if_null: begin
        hit_dsz = 1'b1;
      end
      op_increment_skip_if_null: begin
        hit_isz = 1'b1;
      end
      op_increment_file_reg: begin
        hit_inc = 1'b1;
      end
      op_or_literal_into_acc: begin
        hit_ior = 1'b1;
      end
      default: begin
        hit_ior = 1'b0;
      end
    endcase
  end
  assign hit_jmp = (op3 == op_unconditional_jump);
  // the slot after a two-cycle instruction is never decoded
  assign go = instr_valid && (state_r == st_exec);
  assign is_dsz = go && hit_dsz;
  assign is_isz = go && hit_isz;
  assign is_inc = go && hit_inc;
  assign is_ior = go && hit_ior;
  assign is_jmp = go && hit_jmp;
  assign dest_file = instr[dest_bit];
  assign skip_kind = is_dsz || is_isz;
  assign rmw_kind = is_dsz || is_isz || is_inc;
  // ------------------------------------------------------------
  // arithmetic and zero detect
  // ------------------------------------------------------------
  assign inc_res = file_rdata + one_val;
  assign dec_res = file_rdata - one_val;
  assign ior_res = acc_in | instr[data_w-1:0];
  // zero detect runs beside the result mux, not behind it
  zero_detect #(.width(data_w)) u_inc_zero (
    .value(inc_res),
    .is_zero(inc_zero)
  );
  zero_detect #(.width(data_w)) u_dec_zero (
    .value(dec_res),
    .is_zero(dec_zero)
  );
  zero_detect #(.width(data_w)) u_ior_zero (
    .value(ior_res),
    .is_zero(ior_zero)
  );
  always_comb begin
    if (is_dsz) begin
      res = dec_res;
      res_zero = dec_zero;
    end else if (is_ior) begin
      res = ior_res;
      res_zero = ior_zero;
    end else begin
      res = inc_res;
      res_zero = inc_zero;
    end
  end
  // skip forms flush only on a zero result, the jump always
  assign two_cycle = is_jmp || (skip_kind && res_zero);
  assign acc_write = is_ior || (rmw_kind && !dest_file);
  assign file_write = rmw_kind && dest_file;
  // skip forms and the jump leave the zero flag alone
  assign zero_write = is_inc || is_ior;
  // ------------------------------------------------------------
  // sequencing: two-cycle instructions
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_exec: begin
        if (two_cycle) begin
          state_nxt = st_flush;
        end
      end
      st_flush: begin
        state_nxt = st_exec;
      end
      default: begin
        state_nxt = st_exec;
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= st_exec;
    end else begin
      state_r <= state_nxt;
    end
  end
  // flush tells the fetch side to turn the next word into a no-op
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flush_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      flush_r <= two_cycle;
      busy_r <= two_cycle;
    end
  end
  // ------------------------------------------------------------
  // register writeback
  // ------------------------------------------------------------
  // accumulator port: data holds until the next accumulator write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_we_r <= 1'b0;
      acc_wdata_r <= zero_val;
    end else begin
      acc_we_r <= acc_write;
      if (acc_write) begin
        acc_wdata_r <= res;
      end
    end
  end
  // file port: address and data hold until the next file write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      file_we_r <= 1'b0;
      file_waddr_r <= '0;
      file_wdata_r <= zero_val;
    end else begin
      file_we_r <= file_write;
      if (file_write) begin
        file_waddr_r <= instr[addr_w-1:0];
        file_wdata_r <= res;
      end
    end
  end
  // ------------------------------------------------------------
  // zero flag: skip forms and jump leave it alone
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_we_r <= 1'b0;
      zero_val_r <= 1'b0;
    end else begin
      zero_we_r <= zero_write;
      if (zero_write) begin
        zero_val_r <= res_zero;
      end
    end
  end
  // ------------------------------------------------------------
  // jump target
  // ------------------------------------------------------------
  // page bits come from the latch as it stands when the jump is taken
  assign jump_target = {upper_pc_latch[latch_hi:latch_lo], instr[jump_w-1:0]};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_load_r <= 1'b0;
      pc_target_r <= '0;
    end else begin
      pc_load_r <= is_jmp;
      if (is_jmp) begin
        pc_target_r <= jump_target;
      end
    end
  end
endmodule
`default_nettype wire

// *** core/zero_detect.sv ***
// combinational zero detector, output not registered
`timescale 1ns/10ps
`default_nettype none
module zero_detect #(
  parameter int width = 8
) (
  input wire logic [width-1:0] value,
  output logic is_zero
);
  assign is_zero = (value == '0);
endmodule
`default_nettype wire

// *** shared/exec_pkg.sv ***
// package: opcodes, field positions and widths for the execute block
package exec_pkg;
  localparam int data_w = 8;
  localparam int addr_w = 7;
  localparam int pc_w = 13;
  localparam int jump_w = 11;
  localparam int op_w = 14;
  // opcode patterns (upper bits)
  localparam logic [5:0] op_decrement_skip_if_null = 6'h0b;
  localparam logic [5:0] op_increment_skip_if_null = 6'h0f;
  localparam logic [5:0] op_increment_file_reg = 6'h0a;
  localparam logic [5:0] op_or_literal_into_acc = 6'h38;
  localparam logic [2:0] op_unconditional_jump = 3'h5;
  // field positions
  localparam int dest_bit = 7;
  localparam int op6_lo = 8;
  localparam int op3_lo = 11;
  localparam int latch_hi = 4;
  localparam int latch_lo = 3;
  localparam logic [data_w-1:0] one_val = 8'h01;
  localparam logic [data_w-1:0] zero_val = 8'h00;
  typedef enum logic [1:0] {
    st_exec = 2'b00,
    st_flush = 2'b01
  } exec_state_type;
endpackage

// *** sim/exec_properties.sv ***
// checker: execute block port properties
`timescale 1ns/10ps
`default_nettype none
module exec_properties
  import exec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction and operands
  input wire logic instr_valid,
  input wire logic [op_w-1:0] instr,
  input wire logic [data_w-1:0] file_rdata,
  input wire logic [data_w-1:0] acc_in,
  input wire logic [data_w-1:0] upper_pc_latch,
  // results
  input wire logic acc_we_r,
  input wire logic [data_w-1:0] acc_wdata_r,
  input wire logic file_we_r,
  input wire logic [addr_w-1:0] file_waddr_r,
  input wire logic [data_w-1:0] file_wdata_r,
  input wire logic zero_we_r,
  input wire logic zero_val_r,
  input wire logic pc_load_r,
  input wire logic [pc_w-1:0] pc_target_r,
  input wire logic flush_r
);
  logic tk_r;
  logic [op_w-1:0] op_r;
  logic [data_w-1:0] fd_r, ac_r, lt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tk_r <= 1'h0;
    else tk_r <= instr_valid && !flush_r;
  end
  always_ff @(posedge clk) begin
    op_r <= instr;
    fd_r <= file_rdata;
    ac_r <= acc_in;
    lt_r <= upper_pc_latch;
  end
  wire logic ds = tk_r && op_r[13:8] == op_decrement_skip_if_null;
  wire logic is = tk_r && op_r[13:8] == op_increment_skip_if_null;
  wire logic ip = tk_r && op_r[13:8] == op_increment_file_reg;
  wire logic ol = tk_r && op_r[13:8] == op_or_literal_into_acc;
  wire logic jp = tk_r && op_r[13:11] == op_unconditional_jump;
  wire logic [data_w-1:0] res = ds ? fd_r - one_val : fd_r + one_val;
  wire logic [data_w-1:0] dst = file_we_r ? file_wdata_r : acc_wdata_r;
  // ----------
  // properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_dec_flags: assert property (ds |-> dst == res && !zero_we_r) else $error("dec result or flag wrong");
  chk_dec_skip: assert property (ds |-> flush_r == (res == zero_val)) else $error("dec skip wrong");
  chk_inc_skip: assert property (is |-> dst == res && !zero_we_r && flush_r == (res == zero_val))
    else $error("inc skip wrong");
  chk_dest_route: assert property ((ds || is || ip) |-> file_we_r == op_r[dest_bit]
    && acc_we_r != op_r[dest_bit] && (!file_we_r || file_waddr_r == op_r[6:0])) else $error("destination wrong");
  chk_jump_low: assert property (jp |-> pc_load_r && pc_target_r[10:0] == op_r[10:0]) else $error("jump low");
  chk_jump_page: assert property (jp |-> pc_target_r[12:11] == lt_r[latch_hi:latch_lo])
    else $error("jump page");
  chk_jump_slot: assert property (jp |-> flush_r && !zero_we_r ##1 !pc_load_r && !acc_we_r && !file_we_r)
    else $error("jump slot not consumed");
  chk_or_lit: assert property (ol |-> acc_we_r && acc_wdata_r == (ac_r | op_r[7:0]) && zero_we_r
    && zero_val_r == ((ac_r | op_r[7:0]) == zero_val)) else $error("or literal wrong");
  chk_inc_zero: assert property (ip |-> dst == res && zero_we_r
    && zero_val_r == (res == zero_val) && !flush_r) else $error("increment wrong");
  cover property (ds && flush_r);
  cover property (is && flush_r);
  cover property (jp);
  cover property (ol && zero_val_r);
endmodule
bind inc_dec_skip_jump_or_exec exec_properties u_props (.clk, .rst, .instr_valid, .acc_we_r, .file_we_r,
  .zero_we_r, .zero_val_r, .pc_load_r, .flush_r, .instr, .file_rdata, .acc_in, .upper_pc_latch, .acc_wdata_r,
  .file_wdata_r, .file_waddr_r, .pc_target_r);
`default_nettype wire

// *** sim/tb_top.sv ***
// testbench: directed scenarios for the execute block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import exec_pkg::*;
;
  logic clk = 1'h0, rst = 1'h1, instr_valid = 1'h0, acc_we_r, file_we_r, zero_we_r, zero_val_r, pc_load_r;
  logic flush_r, busy_r;
  logic [op_w-1:0] instr = 14'h0000;
  logic [data_w-1:0] file_rdata = 8'h00, acc_in = 8'h00, upper_pc_latch = 8'h00, acc_wdata_r, file_wdata_r;
  logic [addr_w-1:0] file_waddr_r;
  logic [pc_w-1:0] pc_target_r;
  int fails = 0, checked = 0;
  wire logic [3:0] we = {file_we_r, acc_we_r, zero_we_r, flush_r};
  inc_dec_skip_jump_or_exec u_dut (.clk, .rst, .instr_valid, .instr, .file_rdata, .acc_in, .upper_pc_latch,
    .acc_we_r, .acc_wdata_r, .file_we_r, .file_waddr_r, .file_wdata_r, .zero_we_r, .zero_val_r, .pc_load_r,
    .pc_target_r, .flush_r, .busy_r);
  initial forever #4 clk = ~clk;
  // ---------
  // scenarios
  // ---------
  task automatic check(input logic [23:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic go(input logic [op_w-1:0] i, input logic [data_w-1:0] f, a, l);
    @(negedge clk);
    {instr, file_rdata, acc_in, upper_pc_latch, instr_valid} = {i, f, a, l, 1'h1};
  endtask
  task automatic idle;
    @(negedge clk);
    instr_valid = 1'h0;
  endtask
  task automatic dec_case;
    go({op_decrement_skip_if_null, 1'h1, 7'h05}, 8'h01, 8'h33, 8'h00);
    go({op_increment_file_reg, 1'h0, 7'h05}, 8'h07, 8'h33, 8'h00);
    check({we, file_waddr_r, file_wdata_r}, {4'h9, 7'h05, 8'h00});
    go({op_decrement_skip_if_null, 1'h0, 7'h05}, 8'h00, 8'h33, 8'h00);
    check(we, 4'h0);
    idle;
    check({we, acc_wdata_r}, {4'h4, 8'hff});
  endtask
  task automatic inc_skip_case;
    go({op_increment_skip_if_null, 1'h0, 7'h10}, 8'hff, 8'h12, 8'h00);
    idle;
    check({we, acc_wdata_r}, {4'h5, 8'h00});
    go({op_increment_skip_if_null, 1'h1, 7'h11}, 8'h41, 8'h12, 8'h00);
    idle;
    check({we, file_waddr_r, file_wdata_r}, {4'h8, 7'h11, 8'h42});
  endtask
  task automatic inc_or_case;
    go({op_increment_file_reg, 1'h1, 7'h7f}, 8'hff, 8'h00, 8'h00);
    go({op_increment_file_reg, 1'h0, 7'h01}, 8'h7f, 8'h00, 8'h00);
    check({we, zero_val_r, file_wdata_r}, {4'ha, 1'h1, 8'h00});
    go({op_or_literal_into_acc, 8'h0a}, 8'hff, 8'h50, 8'h00);
    check({we, zero_val_r, acc_wdata_r}, {4'h6, 1'h0, 8'h80});
    go({op_or_literal_into_acc, 8'h00}, 8'h00, 8'h00, 8'h00);
    check({we, zero_val_r, acc_wdata_r}, {4'h6, 1'h0, 8'h5a});
    idle;
    check({we, zero_val_r, acc_wdata_r}, {4'h6, 1'h1, 8'h00});
  endtask
  task automatic jump_case;
    go({op_unconditional_jump, 11'h2aa}, 8'h00, 8'h00, 8'hef);
    go({op_increment_file_reg, 1'h0, 7'h01}, 8'h00, 8'h00, 8'h00);
    check({we, pc_load_r, busy_r, pc_target_r}, {4'h1, 2'h3, 13'h0aaa});
    idle;
    check({we, pc_load_r}, 5'h00);
    go({op_unconditional_jump, 11'h555}, 8'h00, 8'h00, 8'h10);
    idle;
    check(pc_target_r, 13'h1555);
  endtask
  task automatic reset_case;
    go({op_unconditional_jump, 11'h7ff}, 8'h00, 8'h00, 8'h18);
    idle;
    check({we, pc_load_r, busy_r, pc_target_r}, {4'h1, 2'h3, 13'h1fff});
    rst = 1'h1;
    #1;
    check({we, pc_load_r, busy_r, zero_val_r, pc_target_r}, 20'h00000);
    check({file_waddr_r, acc_wdata_r, file_wdata_r}, 23'h000000);
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    {instr, file_rdata, instr_valid} = {op_decrement_skip_if_null, 1'h1, 7'h22, 8'h01, 1'h1};
    idle;
    check({we, file_waddr_r, file_wdata_r}, {4'h9, 7'h22, 8'h00});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    dec_case;
    inc_skip_case;
    inc_or_case;
    jump_case;
    reset_case;
    finish_test;
  end
endmodule
`default_nettype wire
